// ---- rtl/gpp_pkg.sv ----
/*
 * Constants for the eight-pin general purpose port: register
 * indices, control field layout, sense codes and reset values.
 * Assumes a 32-bit APB bus with one register per aligned word.
 */
`default_nettype none
package gpp_pkg;
    localparam int NPIN = 8;
    localparam int ADDR_SHIFT = 2;
    typedef logic [7:0] gpp_byte_t;
    // Register indices; byte address is index times four.
    localparam gpp_byte_t IDX_DIR      = 8'h00;
    localparam gpp_byte_t IDX_DIRSET   = 8'h01;
    localparam gpp_byte_t IDX_DIRCLR   = 8'h02;
    localparam gpp_byte_t IDX_DIRTGL   = 8'h03;
    localparam gpp_byte_t IDX_OUT      = 8'h04;
    localparam gpp_byte_t IDX_OUTPUT_SET_ALIAS   = 8'h05;
    localparam gpp_byte_t IDX_OUTPUT_CLEAR_ALIAS   = 8'h06;
    localparam gpp_byte_t IDX_OUTPUT_TOGGLE_ALIAS   = 8'h07;
    localparam gpp_byte_t IDX_IN       = 8'h08;
    localparam gpp_byte_t IDX_FLAGS    = 8'h09;
    localparam gpp_byte_t IDX_CTRL0    = 8'h10;
    localparam gpp_byte_t IDX_CTRL7    = 8'h17;
    localparam gpp_byte_t IDX_ISTAT    = 8'h18;
    localparam gpp_byte_t IDX_IMASK    = 8'h19;
    // Pin control layout.
    localparam int CTRL_INV_BIT  = 7;
    localparam int CTRL_PULL_BIT = 3;
    localparam gpp_byte_t CTRL_WMASK = 8'h8F;
    localparam gpp_byte_t REG_RESET  = 8'h00;
    // Sense codes.
    localparam logic [2:0] SENSE_NONE  = 3'h0;
    localparam logic [2:0] SENSE_ANY   = 3'h1;
    localparam logic [2:0] SENSE_RISE  = 3'h2;
    localparam logic [2:0] SENSE_FALL  = 3'h3;
    localparam logic [2:0] SENSE_OFF   = 3'h4;
    localparam logic [2:0] SENSE_LOW   = 3'h5;
endpackage
`default_nettype wire

// ---- rtl/gpp_reg_if.sv ----
/*
 * Register access carrier between the APB slave and the port core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface gpp_reg_if;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rvalue;
    logic [7:0] rdata;
    logic       map_ok;
    modport bus  (output idx, wdata, wr, rd, rvalue,
                  input rdata, map_ok);
    modport regs (input idx, wdata, wr, rd, rvalue,
                  output rdata, map_ok);
endinterface
`default_nettype wire

// ---- rtl/gpp_apb.sv ----
/*
 * APB slave front end: zero wait states, read data captured in
 * the setup cycle, error on unmapped or misaligned addresses.
 * Assumes the core answers rdata and map_ok combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
module gpp_apb (
    input  wire logic        clk,     // System clock.
    input  wire logic        srst,    // Sync reset.
    input  wire logic        psel,    // Select.
    input  wire logic        penable, // Access phase.
    input  wire logic        pwrite,  // Direction.
    input  wire logic [11:0] paddr,   // Byte address.
    input  wire logic [31:0] pwdata,  // Write data.
    input  wire logic [3:0]  pstrb,   // Byte strobes.
    output logic      [31:0] prdata,  // Read data.
    output logic             pready,  // Ready.
    output logic             pslverr, // Error.
    gpp_reg_if.bus           rb       // Core side.
);
    logic ok;
    logic access;

    assign rb.idx   = paddr[9:2];
    assign ok       = rb.map_ok && paddr[1:0] == 2'b00
                      && paddr[11:10] == 2'b00;
    assign access   = psel && penable;
    assign pready   = 1'b1;
    assign pslverr  = access && !ok;
    assign rb.wdata = pwdata[7:0];
    // A write without lane zero stores nothing.
    assign rb.wr    = access && pwrite && ok && pstrb[0];
    assign rb.rd    = access && !pwrite && ok;
    assign rb.rvalue = prdata[7:0];

    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= (!pwrite && ok) ? {24'h00_0000, rb.rdata}
                                      : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/gpp_sense.sv ----
/*
 * Per-pin input sampling and sense matching.
 * Assumes pin levels are synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gpp_sense #(
    parameter int N = 8
) (
    input  wire logic              clk,      // System clock.
    input  wire logic              srst,     // Sync reset.
    input  wire logic [N-1:0]      pin_in,   // Pin levels.
    input  wire logic [N-1:0]      inv,      // Polarity invert.
    input  wire logic [N-1:0][2:0] sense,    // Sense select.
    output logic      [N-1:0]      in_value, // Sampled levels.
    output logic      [N-1:0]      evt       // Sense matches.
);
    function automatic logic hit(input logic [2:0] code,
                                 input logic old, input logic cur);
        case (code)
            gpp_pkg::SENSE_ANY:  hit = old ^ cur;
            gpp_pkg::SENSE_RISE: hit = cur & ~old;
            gpp_pkg::SENSE_FALL: hit = old & ~cur;
            gpp_pkg::SENSE_LOW:  hit = ~cur;
            default:             hit = 1'b0;
        endcase
    endfunction

    for (genvar n = 0; n < N; n++) begin : g_pin
        logic cur;
        logic buf_on;
        assign cur    = pin_in[n] ^ inv[n];
        assign buf_on = sense[n] != gpp_pkg::SENSE_OFF;
        // Level sense keeps firing while the pin level after invert stays low.
        assign evt[n] = buf_on && hit(sense[n], in_value[n], cur);
        always_ff @(posedge clk) begin
            if (srst) begin
                in_value[n] <= 1'b0;
            end else if (buf_on) begin
                in_value[n] <= cur;
            end
        end
        buf_hold_a: assert property (@(posedge clk) disable iff (srst)
            sense[n] == gpp_pkg::SENSE_OFF |=> $stable(in_value[n]))
            else $error("sampled bit moved with buffer off");
        level_fire_a: assert property (@(posedge clk) disable iff (srst)
            sense[n] == gpp_pkg::SENSE_LOW && pin_in[n] == inv[n]
            |-> evt[n])
            else $error("low level did not raise event");
    end
endmodule
`default_nettype wire

// ---- rtl/gpp_port.sv ----
/*
 * Eight-pin general purpose port core: direction and output value
 * with atomic aliases, input sampling, per-pin sense flags,
 * polarity, pull-up control and a masked interrupt output.
 * Assumes an APB master on CLK and pins synchronous to CLK.
 */
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Output bit one drives high, zero low.
// - Output value matters only while driver enabled.
// - Set alias sets bits written one.
// - Clear alias clears bits written one.
// - Toggle alias inverts bits written one.
// - Alias reads return the output value.
// - Input register shows sampled pin levels.
// - Writing one to input toggles output bit.
// - Disabled buffer freezes the input bit.
// - Sense match sets the pin flag.
// - Writing one clears a pin flag.
// - Per-pin control: invert, pull-up, sense.
// - Invert flips driven and sampled values.
// - Pull-up only on input-only pins.
// - Codes: none, both, rising, falling edges.
// - Code four disables buffer; five low level.
// - Direction one enables the driver.
module gpp_port (
    input  wire logic        CLK,     // 200 MHz clock.
    input  wire logic        SRST,    // Sync reset, high.
    input  wire logic        PSEL,    // APB select.
    input  wire logic        PENABLE, // APB access phase.
    input  wire logic        PWRITE,  // APB direction.
    input  wire logic [11:0] PADDR,   // APB byte address.
    input  wire logic [31:0] PWDATA,  // APB write data.
    input  wire logic [3:0]  PSTRB,   // APB byte strobes.
    output logic      [31:0] PRDATA,  // APB read data.
    output logic             PREADY,  // APB ready.
    output logic             PSLVERR, // APB error.
    input  wire logic [7:0]  PIN_IN,  // Pin levels.
    output logic      [7:0]  PIN_OUT, // Pin drive level.
    output logic      [7:0]  PIN_OE,  // Pin driver enable.
    output logic      [7:0]  PIN_PU,  // Pull-up enable.
    output logic             PORT_IRQ, // Any pin flag set.
    output logic             IRQ      // Masked event status.
);
    localparam int N = gpp_pkg::NPIN;

    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    gpp_reg_if rb ();

    logic [N-1:0]       dir;
    logic [N-1:0]       out_value;
    logic [N-1:0][7:0]  ctrl;
    logic [N-1:0]       pin_flags;
    logic [N-1:0]       irq_status;
    logic [N-1:0]       irq_mask;
    logic [N-1:0]       in_value;
    logic [N-1:0]       evt;
    logic [N-1:0]       inv;
    logic [N-1:0]       pull;
    logic [N-1:0][2:0]  sense;
    logic [N-1:0]       next_out;
    logic [N-1:0]       next_dir;

    // ----------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------
    function automatic logic is_ctrl(input logic [7:0] i);
        is_ctrl = i >= gpp_pkg::IDX_CTRL0
                  && i <= gpp_pkg::IDX_CTRL7;
    endfunction

    function automatic logic mapped(input logic [7:0] i);
        if (i <= gpp_pkg::IDX_FLAGS) begin
            mapped = 1'b1;
        end else if (is_ctrl(i)) begin
            mapped = 1'b1;
        end else if (i == gpp_pkg::IDX_ISTAT) begin
            mapped = 1'b1;
        end else if (i == gpp_pkg::IDX_IMASK) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    endfunction

    function automatic logic wr_at(input logic [7:0] i);
        wr_at = rb.wr && rb.idx == i;
    endfunction

    // ----------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------
    gpp_apb u_apb (
        .clk     (CLK),
        .srst    (SRST),
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pwdata  (PWDATA),
        .pstrb   (PSTRB),
        .prdata  (PRDATA),
        .pready  (PREADY),
        .pslverr (PSLVERR),
        .rb      (rb.bus)
    );

    assign rb.map_ok = mapped(rb.idx);

    always_comb begin
        rb.rdata = gpp_pkg::REG_RESET;
        if (rb.idx <= gpp_pkg::IDX_DIRTGL) begin
            rb.rdata = dir;
        end else if (rb.idx <= gpp_pkg::IDX_OUTPUT_TOGGLE_ALIAS) begin
            rb.rdata = out_value;
        end else if (rb.idx == gpp_pkg::IDX_IN) begin
            rb.rdata = in_value;
        end else if (rb.idx == gpp_pkg::IDX_FLAGS) begin
            rb.rdata = pin_flags;
        end else if (is_ctrl(rb.idx)) begin
            rb.rdata = ctrl[rb.idx[2:0]];
        end else if (rb.idx == gpp_pkg::IDX_ISTAT) begin
            rb.rdata = irq_status;
        end else if (rb.idx == gpp_pkg::IDX_IMASK) begin
            rb.rdata = irq_mask;
        end
    end

    // ----------------------------------------------------------
    // Direction
    // ----------------------------------------------------------
    always_comb begin
        next_dir = dir;
        if (wr_at(gpp_pkg::IDX_DIR)) begin
            next_dir = rb.wdata;
        end else if (wr_at(gpp_pkg::IDX_DIRSET)) begin
            next_dir = dir | rb.wdata;
        end else if (wr_at(gpp_pkg::IDX_DIRCLR)) begin
            next_dir = dir & ~rb.wdata;
        end else if (wr_at(gpp_pkg::IDX_DIRTGL)) begin
            next_dir = dir ^ rb.wdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            dir <= gpp_pkg::REG_RESET;
        end else begin
            dir <= next_dir;
        end
    end

    // ----------------------------------------------------------
    // Output value and its aliases
    // ----------------------------------------------------------
    always_comb begin
        next_out = out_value;
        if (wr_at(gpp_pkg::IDX_OUT)) begin
            next_out = rb.wdata;
        end else if (wr_at(gpp_pkg::IDX_OUTPUT_SET_ALIAS)) begin
            next_out = out_value | rb.wdata;
        end else if (wr_at(gpp_pkg::IDX_OUTPUT_CLEAR_ALIAS)) begin
            next_out = out_value & ~rb.wdata;
        end else if (wr_at(gpp_pkg::IDX_OUTPUT_TOGGLE_ALIAS)) begin
            next_out = out_value ^ rb.wdata;
        end else if (wr_at(gpp_pkg::IDX_IN)) begin
            next_out = out_value ^ rb.wdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            out_value <= gpp_pkg::REG_RESET;
        end else begin
            out_value <= next_out;
        end
    end

    // ----------------------------------------------------------
    // Pin control array
    // ----------------------------------------------------------
    // Reserved bits 6:4 are never stored, so they read as zero.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl <= '0;
        end else if (rb.wr && is_ctrl(rb.idx)) begin
            ctrl[rb.idx[2:0]] <= rb.wdata & gpp_pkg::CTRL_WMASK;
        end
    end

    for (genvar n = 0; n < N; n++) begin : g_ctrl
        assign inv[n]   = ctrl[n][gpp_pkg::CTRL_INV_BIT];
        assign pull[n]  = ctrl[n][gpp_pkg::CTRL_PULL_BIT];
        assign sense[n] = ctrl[n][2:0];
    end

    // ----------------------------------------------------------
    // Pins
    // ----------------------------------------------------------
    // The drive level is always presented; the enable alone decides
    // whether the pad follows it.
    assign PIN_OUT = out_value ^ inv;
    assign PIN_OE  = dir;
    assign PIN_PU  = pull & ~dir;

    gpp_sense #(
        .N (N)
    ) u_sense (
        .clk      (CLK),
        .srst     (SRST),
        .pin_in   (PIN_IN),
        .inv      (inv),
        .sense    (sense),
        .in_value (in_value),
        .evt      (evt)
    );

    // ----------------------------------------------------------
    // Flags and interrupt
    // ----------------------------------------------------------
    // A match in the clearing cycle wins, so no event is lost.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_flags <= gpp_pkg::REG_RESET;
        end else begin
            pin_flags <= (pin_flags
                & ~(wr_at(gpp_pkg::IDX_FLAGS) ? rb.wdata
                                              : 8'h00))
                | evt;
        end
    end

    // Read clears only the bits that were actually returned, so an
    // event arriving between setup and access stays pending.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_status <= gpp_pkg::REG_RESET;
        end else begin
            irq_status <= (irq_status
                & ~((rb.rd && rb.idx == gpp_pkg::IDX_ISTAT)
                    ? rb.rvalue : 8'h00))
                | evt;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_mask <= gpp_pkg::REG_RESET;
        end else if (wr_at(gpp_pkg::IDX_IMASK)) begin
            irq_mask <= rb.wdata;
        end
    end

    assign PORT_IRQ = |pin_flags;
    assign IRQ      = |(irq_status & irq_mask);

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_wr(logic [7:0] i);
        rb.wr && rb.idx == i;
    endsequence

    out_set_a: assert property (
        s_wr(gpp_pkg::IDX_OUTPUT_SET_ALIAS) |=>
            out_value == ($past(out_value) | $past(rb.wdata)))
        else $error("set alias wrong");

    out_clr_a: assert property (
        s_wr(gpp_pkg::IDX_OUTPUT_CLEAR_ALIAS) |=>
            out_value == ($past(out_value) & ~$past(rb.wdata)))
        else $error("clear alias wrong");

    out_tgl_a: assert property (
        s_wr(gpp_pkg::IDX_OUTPUT_TOGGLE_ALIAS) |=>
            out_value == ($past(out_value) ^ $past(rb.wdata)))
        else $error("toggle alias wrong");

    in_toggle_a: assert property (
        s_wr(gpp_pkg::IDX_IN) |=>
            PIN_OUT == ($past(PIN_OUT) ^ $past(rb.wdata)))
        else $error("input write did not toggle output");

    alias_read_a: assert property (
        rb.rd && rb.idx >= gpp_pkg::IDX_OUTPUT_SET_ALIAS
        && rb.idx <= gpp_pkg::IDX_OUTPUT_TOGGLE_ALIAS
        |-> PRDATA == {24'h00_0000, out_value})
        else $error("alias read wrong");

    flag_clear_a: assert property (
        s_wr(gpp_pkg::IDX_FLAGS) && evt == 8'h00 |=>
            (pin_flags & $past(rb.wdata)) == 8'h00
            && (pin_flags | $past(rb.wdata))
               == ($past(pin_flags) | $past(rb.wdata)))
        else $error("flag clear wrong");

    flag_set_a: assert property (
        evt != 8'h00 |=> (pin_flags & $past(evt)) == $past(evt)
                         ##0 PORT_IRQ)
        else $error("event not flagged");

    pull_dir_a: assert property (
        s_wr(gpp_pkg::IDX_DIRSET) |=>
            (PIN_PU & $past(rb.wdata)) == 8'h00)
        else $error("pull-up left on driven pin");

    drive_dir_a: assert property (
        s_wr(gpp_pkg::IDX_DIRCLR) |=>
            (PIN_OE & $past(rb.wdata)) == 8'h00)
        else $error("driver left enabled");

    in_read_a: assert property (
        rb.rd && rb.idx == gpp_pkg::IDX_IN
        |-> PRDATA[7:0] == $past(in_value))
        else $error("input read wrong");

    ctrl_rsvd_a: assert property (
        rb.rd && is_ctrl(rb.idx) |-> PRDATA[6:4] == 3'b000)
        else $error("reserved control bits read nonzero");

    out_write_a: assert property (
        s_wr(gpp_pkg::IDX_OUT) |=>
            PIN_OUT == ($past(rb.wdata) ^ $past(inv)))
        else $error("output write not driven");

    dir_write_a: assert property (
        s_wr(gpp_pkg::IDX_DIR) |=> PIN_OE == $past(rb.wdata))
        else $error("direction write not applied");

    pull_on_a: assert property (
        s_wr(gpp_pkg::IDX_DIRCLR) |=>
            (PIN_PU & $past(rb.wdata)) == (pull & $past(rb.wdata)))
        else $error("pull-up not on for input-only pin");

endmodule
`default_nettype wire

// ---- sim/gpp_pins.sv ----
/*
 * Board model for the eight port pins: device drive, board drive,
 * pull-up and a floating pattern on pins that nobody holds.
 * Assumes it is clocked by the system clock of the port.
 */
`timescale 1ns/1ps
`default_nettype none
module gpp_pins (
    input  wire logic       clk,    // System clock.
    input  wire logic [7:0] drv,    // Device drive level.
    input  wire logic [7:0] oe,     // Device driver enable.
    input  wire logic [7:0] pu,     // Pull-up enable.
    input  wire logic [7:0] ext,    // Board drive level.
    input  wire logic [7:0] ext_en, // Board drive enable.
    output logic      [7:0] level   // Resolved pin level.
);
    logic [7:0] flt = 8'h00;

    // A floating pin changes every cycle, so a missing pull-up shows.
    always @(posedge clk) begin
        flt <= ~flt;
    end

    // The device driver wins; the bench keeps its drive enabled on driven pins except in the pull-up test.
    assign level = (oe & drv) | (~oe & ext_en & ext)
                 | (~oe & ~ext_en & (pu | flt));
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for the eight-pin port: APB master tasks,
 * random and corner stimulus, expected values from bench functions.
 * Assumes the port core and the board model of this folder.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [3:0]  strb = 4'h1;
    logic [7:0]  ext = 8'h00;
    logic [7:0]  ext_en = 8'hFF;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, port_irq, irq, err;
    logic [7:0]  pin_out, pin_oe, pin_pu, pin_lvl;
    logic [7:0]  out_m, dir_m, inv_m, a, d, f, l0, l1, lv, frz;
    int          n_fail = 0;
    int          checked = 0;

    always #2.5 clk = ~clk;

    gpp_port gpp_port_inst (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PIN_IN(pin_lvl), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .PIN_PU(pin_pu), .PORT_IRQ(port_irq),
        .IRQ(irq)
    );

    gpp_pins gpp_pins_inst (
        .clk(clk), .drv(pin_out), .oe(pin_oe), .pu(pin_pu),
        .ext(ext), .ext_en(ext_en), .level(pin_lvl)
    );

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] dat);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, dat};
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            chk("pready", {7'h00, pready}, 8'h01);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        apb(1'b1, idx, dat);
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx,
                       input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(nm, rd[7:0], e);
    endtask

    // Index zero of a group is the plain register, then set, clear
    // and toggle; the input register toggles like the toggle alias.
    function automatic logic [7:0] exp_alias(int k, logic [7:0] old,
                                             logic [7:0] v);
        case (k)
            0: return v;
            1: return old | v;
            2: return old & ~v;
            default: return old ^ v;
        endcase
    endfunction

    function automatic logic [7:0] exp_flags(int c, logic [7:0] p,
                                             logic [7:0] q);
        case (c)
            1: return p ^ q;
            2: return ~p & q;
            3: return p & ~q;
            5: return ~(p & q);
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'he54b2192));
        out_m = 8'h00;
        dir_m = 8'h00;
        lv = 8'h00;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("pin_oe", pin_oe, 8'h00);
        chk("pin_out", pin_out, 8'h00);
        rdc("out", gpp_pkg::IDX_OUT, 8'h00);
        rdc("ctrl", gpp_pkg::IDX_CTRL7, 8'h00);
        $display("test reset done");

        for (int i = 0; i < 24; i++) begin
            a = 8'(4 + $urandom_range(4));
            d = 8'($urandom);
            wr(a, d);
            out_m = exp_alias(int'(a) - 4, out_m, d);
            a = 8'($urandom_range(3));
            d = 8'($urandom);
            wr(a, d);
            dir_m = exp_alias(int'(a), dir_m, d);
            rdc("out_alias", 8'(5 + $urandom_range(2)), out_m);
            chk("pin_oe", pin_oe, dir_m);
            chk("pin_out", pin_out, out_m);
        end
        $display("test aliases done");

        wr(gpp_pkg::IDX_DIR, 8'h00);
        inv_m = 8'($urandom);
        ext <= 8'($urandom);
        for (int n = 0; n < 8; n++) begin
            wr(8'(gpp_pkg::IDX_CTRL0 + n), {inv_m[n], 7'h00});
        end
        repeat (2) @(posedge clk);
        rdc("in_inv", gpp_pkg::IDX_IN, ext ^ inv_m);
        chk("pin_out_inv", pin_out, out_m ^ inv_m);
        lv = ext;
        $display("test invert done");

        for (int c = 0; c < 8; c++) begin
            for (int n = 0; n < 8; n++) begin
                wr(8'(gpp_pkg::IDX_CTRL0 + n), 8'(8'h70 | (n % 2) * 8 | c));
            end
            rdc("ctrl", 8'(gpp_pkg::IDX_CTRL0 + 3), 8'(8'h08 | c));
            frz = lv;
            l0 = 8'($urandom);
            l1 = 8'($urandom);
            ext <= l0;
            repeat (3) @(posedge clk);
            wr(gpp_pkg::IDX_FLAGS, 8'hFF);
            ext <= l1;
            repeat (3) @(posedge clk);
            f = exp_flags(c, l0, l1);
            rdc("flags", gpp_pkg::IDX_FLAGS, f);
            rdc("in", gpp_pkg::IDX_IN, (c == 4) ? frz : l1);
            chk("port_irq", {7'h00, port_irq}, {7'h00, f != 0});
            wr(gpp_pkg::IDX_FLAGS, 8'h0F);
            rdc("flags_w1c", gpp_pkg::IDX_FLAGS,
                (f & 8'hF0) | ((c == 5) ? ~l1 : 8'h00));
            lv = l1;
        end
        $display("test sense done");

        wr(gpp_pkg::IDX_DIR, 8'h0F);
        chk("pin_pu", pin_pu, 8'hA0);
        ext_en <= 8'h00;
        repeat (3) @(posedge clk);
        apb(1'b0, gpp_pkg::IDX_IN, 8'h00);
        chk("in_pull", rd[7:0] & 8'hAF, (out_m & 8'h0F) | 8'hA0);
        ext_en <= 8'hFF;
        wr(gpp_pkg::IDX_DIR, 8'h00);
        $display("test pull-up done");

        ext <= 8'h00;
        for (int n = 0; n < 8; n++) begin
            wr(8'(gpp_pkg::IDX_CTRL0 + n), 8'h02);
        end
        wr(gpp_pkg::IDX_FLAGS, 8'hFF);
        apb(1'b0, gpp_pkg::IDX_ISTAT, 8'h00);
        wr(gpp_pkg::IDX_IMASK, 8'h00);
        ext <= 8'h03;
        repeat (3) @(posedge clk);
        chk("irq_masked", {7'h00, irq}, 8'h00);
        chk("port_irq", {7'h00, port_irq}, 8'h01);
        wr(gpp_pkg::IDX_IMASK, 8'h01);
        chk("irq", {7'h00, irq}, 8'h01);
        rdc("status", gpp_pkg::IDX_ISTAT, 8'h03);
        chk("irq_clr", {7'h00, irq}, 8'h00);
        rdc("status_clr", gpp_pkg::IDX_ISTAT, 8'h00);
        $display("test interrupt done");

        apb(1'b0, 8'h0A, 8'h00);
        chk("rd_err", {7'h00, err}, 8'h01);
        chk("rd_data", rd[7:0], 8'h00);
        apb(1'b1, 8'h0A, 8'hFF);
        chk("wr_err", {7'h00, err}, 8'h01);
        strb = 4'h0;
        wr(gpp_pkg::IDX_OUT, ~out_m);
        strb = 4'h1;
        rdc("strb_off", gpp_pkg::IDX_OUT, out_m);
        $display("test unmapped done");
        report_and_stop();
    end
endmodule
`default_nettype wire
